// *** verilog/char_lcd_pkg.sv ***
// constants, types and shared functions of the character display host port
`default_nettype none
package char_lcd_pkg;
  // clock and execution times
  localparam int CLK_PERIOD_NS = 50;
  localparam int LONG_EXEC_NS  = 1_530_000;
  localparam int SHORT_EXEC_NS = 39_000;
  localparam int DATA_EXEC_NS  = 43_000;
  localparam int LONG_EXEC_CYC =
    (LONG_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_EXEC_CYC =
    (SHORT_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_EXEC_CYC =
    (DATA_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W        = 16;
  // memory geometry
  localparam int DISP_CHARS    = 80;
  localparam int LINE_CHARS    = 20;
  localparam int GLYPH_BYTES   = 64;
  localparam logic [4:0] LAST_COL = 5'h13;
  // bit positions of instruction codes and fields
  localparam int OP_DISP_BIT   = 7;
  localparam int OP_GLYPH_BIT  = 6;
  localparam int OP_FUNC_BIT   = 5;
  localparam int OP_SHIFT_BIT  = 4;
  localparam int OP_DCTL_BIT   = 3;
  localparam int OP_ENTRY_BIT  = 2;
  localparam int OP_HOME_BIT   = 1;
  localparam int OP_CLEAR_BIT  = 0;
  localparam int ENTRY_INC_BIT = 1;
  localparam int DCTL_ON_BIT   = 2;
  localparam int FUNC_FONT_BIT = 2;
  // reset values
  localparam logic [7:0] RST_ADDR  = 8'h00;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic       RST_INC   = 1'b1;
  localparam logic       RST_ON    = 1'b0;
  localparam logic       RST_TALL  = 1'b0;

  typedef enum logic [3:0] {
    OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DCTL,
    OP_SHIFT, OP_FUNC, OP_GLYPH_ADDR, OP_DISP_ADDR
  } op_e;

  // host pins sampled together
  typedef struct packed {
    logic       register_select;
    logic       read_write;
    logic [7:0] data;
  } pin_s;

  // line and column to display memory index
  function automatic logic [6:0] disp_index(input logic [1:0] line,
                                            input logic [4:0] col);
    disp_index = 7'(7'(line) * 7'd20 + 7'(col));
  endfunction : disp_index

  // highest set bit selects the instruction
  function automatic op_e decode_op(input logic [7:0] code);
    if      (code[OP_DISP_BIT])  decode_op = OP_DISP_ADDR;
    else if (code[OP_GLYPH_BIT]) decode_op = OP_GLYPH_ADDR;
    else if (code[OP_FUNC_BIT])  decode_op = OP_FUNC;
    else if (code[OP_SHIFT_BIT]) decode_op = OP_SHIFT;
    else if (code[OP_DCTL_BIT])  decode_op = OP_DCTL;
    else if (code[OP_ENTRY_BIT]) decode_op = OP_ENTRY;
    else if (code[OP_HOME_BIT])  decode_op = OP_HOME;
    else if (code[OP_CLEAR_BIT]) decode_op = OP_CLEAR;
    else                         decode_op = OP_NONE;
  endfunction : decode_op
endpackage : char_lcd_pkg
`default_nettype wire

// *** verilog/char_lcd_host_port.sv ***
// host port, address counter, memories and scan lookup of the display
`default_nettype none
module char_lcd_host_port #(
  parameter int LONG_EXEC_CYCLES = char_lcd_pkg::LONG_EXEC_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       register_select,
  input  wire logic       read_write,
  input  wire logic       strobe,
  input  wire logic [7:0] bus_in,
  input  wire logic [1:0] scan_line,
  input  wire logic [4:0] scan_col,
  input  wire logic [3:0] scan_row,
  output logic      [7:0] bus_out,
  output logic            bus_oe_n,
  output logic            busy_flag,
  output logic      [4:0] pixel_row
);
  localparam int BW = char_lcd_pkg::BUSY_W;

  // pin synchronisers, filtered pins and held sample
  logic [2:0]         stb_sync_r;
  logic [2:0]         stb_sync_nxt;
  logic               stb_f_r, stb_f_nxt;
  char_lcd_pkg::pin_s pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, hold_r;
  char_lcd_pkg::pin_s pin_now, pin_f_nxt, hold_nxt, agree;
  logic               stb_fall;

  // control state
  logic [7:0]    ac_r, ac_nxt;
  logic          sel_glyph_r, sel_glyph_nxt;
  logic          inc_r, inc_nxt;
  logic          disp_on_r, disp_on_nxt;
  logic          font_tall_r, font_tall_nxt;
  logic [BW-1:0] busy_cnt_r, busy_cnt_nxt;
  logic          clearing_r, clearing_nxt;
  logic [6:0]    clr_idx_r, clr_idx_nxt;
  logic [7:0]    instruction_register_r, instruction_register_nxt;
  logic [7:0]    data_register_r, data_register_nxt;
  logic          busy_flag_nxt;
  char_lcd_pkg::op_e op;

  // memories and their write port
  logic [7:0] disp_mem  [char_lcd_pkg::DISP_CHARS];
  logic [7:0] glyph_mem [char_lcd_pkg::GLYPH_BYTES];
  logic       disp_we, glyph_we;
  logic [6:0] disp_wa;
  logic [7:0] mem_wd;
  logic [6:0] ac_idx;
  logic       ac_valid;
  logic [7:0] ac_rd;

  // bus and scan outputs
  logic [7:0] bus_out_nxt;
  logic       bus_oe_n_nxt;
  logic [4:0] pixel_nxt;

  // next address after a data access in the chosen direction
  function automatic logic [7:0] step_addr(input logic [7:0] a,
                                           input logic up,
                                           input logic glyph);
    if (glyph)
      step_addr = {2'b00, up ? 6'(a[5:0] + 6'd1) : 6'(a[5:0] - 6'd1)};
    else if (up && a[4:0] >= char_lcd_pkg::LAST_COL)
      step_addr = {2'(a[7:6] + 2'd1), 6'h00};
    else if (!up && a[4:0] == 5'h00)
      step_addr = {2'(a[7:6] - 2'd1), 1'b0, char_lcd_pkg::LAST_COL};
    else
      step_addr = up ? 8'(a + 8'h01) : 8'(a - 8'h01);
  endfunction : step_addr

  // fixed glyph pattern row, five dots wide
  function automatic logic [4:0] rom_row(input logic [7:0] code,
                                         input logic [3:0] row);
    rom_row = code[4:0] ^ {row, 1'b0};
  endfunction : rom_row

  // filter pins: a bit changes once stages two and three agree
  always_comb begin
    pin_now.register_select = register_select;
    pin_now.read_write      = read_write;
    pin_now.data            = bus_in;
    stb_sync_nxt = {stb_sync_r[1:0], strobe};
    stb_f_nxt    = (stb_sync_r[1] == stb_sync_r[2]) ? stb_sync_r[2]
                                                    : stb_f_r;
    agree        = ~(pin_s2_r ^ pin_s3_r);
    pin_f_nxt    = (pin_s3_r & agree) | (pin_f_r & ~agree);
    hold_nxt     = stb_f_r ? pin_f_r : hold_r;
    stb_fall     = stb_f_r && (stb_sync_r[1] == stb_sync_r[2])
                   && !stb_sync_r[2];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stb_sync_r <= 3'b000;
      stb_f_r    <= 1'b0;
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_s3_r   <= '0;
      pin_f_r    <= '0;
      hold_r     <= '0;
    end else begin
      stb_sync_r <= stb_sync_nxt;
      stb_f_r    <= stb_f_nxt;
      pin_s1_r   <= pin_now;
      pin_s2_r   <= pin_s1_r;
      pin_s3_r   <= pin_s2_r;
      pin_f_r    <= pin_f_nxt;
      hold_r     <= hold_nxt;
    end
  end

  // address decode and memory read at the address counter
  always_comb begin
    ac_idx   = char_lcd_pkg::disp_index(ac_r[7:6], ac_r[4:0]);
    ac_valid = !ac_r[5] && ac_r[4:0] <= char_lcd_pkg::LAST_COL;
    if (sel_glyph_r)
      ac_rd = glyph_mem[ac_r[5:0]];
    else
      ac_rd = ac_valid ? disp_mem[ac_idx] : 8'h00;
  end

  // host transfers, instruction execution and busy timing
  always_comb begin
    ac_nxt                   = ac_r;
    sel_glyph_nxt            = sel_glyph_r;
    inc_nxt                  = inc_r;
    disp_on_nxt              = disp_on_r;
    font_tall_nxt            = font_tall_r;
    busy_cnt_nxt             = busy_cnt_r;
    clearing_nxt             = clearing_r;
    clr_idx_nxt              = clr_idx_r;
    instruction_register_nxt = instruction_register_r;
    data_register_nxt        = data_register_r;
    disp_we                  = 1'b0;
    glyph_we                 = 1'b0;
    disp_wa                  = ac_idx;
    mem_wd                   = hold_r.data;
    op = char_lcd_pkg::decode_op(instruction_register_r);
    // count down; reload data register as the operation ends
    if (busy_cnt_r != '0) begin
      busy_cnt_nxt = BW'(busy_cnt_r - 1'b1);
      if (busy_cnt_r == BW'(1))
        data_register_nxt = ac_rd;
    end
    // clear fills display memory one entry per cycle
    if (clearing_r) begin
      disp_we = 1'b1;
      disp_wa = clr_idx_r;
      mem_wd  = 8'h00;
      clr_idx_nxt = 7'(clr_idx_r + 7'd1);
      if (clr_idx_r == 7'(char_lcd_pkg::DISP_CHARS - 1))
        clearing_nxt = 1'b0;
    end
    if (stb_fall && busy_cnt_r == '0) begin
      unique case ({hold_r.register_select, hold_r.read_write})
        2'b00: begin
          instruction_register_nxt = hold_r.data;
          op = char_lcd_pkg::decode_op(hold_r.data);
          busy_cnt_nxt = BW'(char_lcd_pkg::SHORT_EXEC_CYC);
          unique case (op)
            char_lcd_pkg::OP_CLEAR: begin
              busy_cnt_nxt  = BW'(LONG_EXEC_CYCLES);
              clearing_nxt  = 1'b1;
              clr_idx_nxt   = 7'd0;
              ac_nxt        = char_lcd_pkg::RST_ADDR;
              sel_glyph_nxt = 1'b0;
              inc_nxt       = char_lcd_pkg::RST_INC;
            end
            char_lcd_pkg::OP_HOME: begin
              busy_cnt_nxt  = BW'(LONG_EXEC_CYCLES);
              ac_nxt        = char_lcd_pkg::RST_ADDR;
              sel_glyph_nxt = 1'b0;
            end
            char_lcd_pkg::OP_ENTRY:
              inc_nxt = hold_r.data[char_lcd_pkg::ENTRY_INC_BIT];
            char_lcd_pkg::OP_DCTL:
              disp_on_nxt = hold_r.data[char_lcd_pkg::DCTL_ON_BIT];
            char_lcd_pkg::OP_FUNC:
              font_tall_nxt = hold_r.data[char_lcd_pkg::FUNC_FONT_BIT];
            char_lcd_pkg::OP_GLYPH_ADDR: begin
              ac_nxt        = {2'b00, hold_r.data[5:0]};
              sel_glyph_nxt = 1'b1;
            end
            char_lcd_pkg::OP_DISP_ADDR: begin
              ac_nxt        = {1'b0, hold_r.data[6:0]};
              sel_glyph_nxt = 1'b0;
            end
            char_lcd_pkg::OP_SHIFT: ;
            char_lcd_pkg::OP_NONE:
              busy_cnt_nxt = '0;
          endcase
        end
        2'b10: begin
          data_register_nxt = hold_r.data;
          glyph_we = sel_glyph_r;
          disp_we  = !sel_glyph_r && ac_valid;
          ac_nxt   = step_addr(ac_r, inc_r, sel_glyph_r);
          busy_cnt_nxt = BW'(char_lcd_pkg::DATA_EXEC_CYC);
        end
        2'b11: begin
          ac_nxt   = step_addr(ac_r, inc_r, sel_glyph_r);
          busy_cnt_nxt = BW'(char_lcd_pkg::DATA_EXEC_CYC);
        end
        2'b01: ;
      endcase
    end
    busy_flag_nxt = (busy_cnt_nxt != '0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ac_r                   <= char_lcd_pkg::RST_ADDR;
      sel_glyph_r            <= 1'b0;
      inc_r                  <= char_lcd_pkg::RST_INC;
      disp_on_r              <= char_lcd_pkg::RST_ON;
      font_tall_r            <= char_lcd_pkg::RST_TALL;
      busy_cnt_r             <= '0;
      clearing_r             <= 1'b0;
      clr_idx_r              <= 7'd0;
      instruction_register_r <= char_lcd_pkg::RST_BYTE;
      data_register_r        <= char_lcd_pkg::RST_BYTE;
      busy_flag              <= 1'b0;
    end else begin
      ac_r                   <= ac_nxt;
      sel_glyph_r            <= sel_glyph_nxt;
      inc_r                  <= inc_nxt;
      disp_on_r              <= disp_on_nxt;
      font_tall_r            <= font_tall_nxt;
      busy_cnt_r             <= busy_cnt_nxt;
      clearing_r             <= clearing_nxt;
      clr_idx_r              <= clr_idx_nxt;
      instruction_register_r <= instruction_register_nxt;
      data_register_r        <= data_register_nxt;
      busy_flag              <= busy_flag_nxt;
    end
  end

  // memory arrays, contents undefined until written or cleared
  always_ff @(posedge mclk) begin
    if (disp_we)
      disp_mem[disp_wa] <= mem_wd;
    if (glyph_we)
      glyph_mem[ac_r[5:0]] <= mem_wd;
  end

  // read drive while strobe high with read selected
  always_comb begin
    bus_oe_n_nxt = !(stb_f_r && pin_f_r.read_write);
    if (pin_f_r.register_select)
      bus_out_nxt = data_register_r;
    else
      bus_out_nxt = {busy_flag, ac_r[6:0]};
  end

  // glyph lookup for the scanned character cell
  always_comb begin
    logic [7:0] code;
    logic [5:0] ga;
    logic       row_ok;
    code   = 8'h00;
    ga     = 6'h00;
    row_ok = 1'b0;
    pixel_nxt = 5'h00;
    if (scan_col <= char_lcd_pkg::LAST_COL) begin
      code = disp_mem[char_lcd_pkg::disp_index(scan_line, scan_col)];
      row_ok = font_tall_r ? (scan_row <= 4'd9) : !scan_row[3];
      ga = font_tall_r ? {code[2:1], scan_row}
                       : {code[2:0], scan_row[2:0]};
      if (disp_on_r && row_ok)
        pixel_nxt = (code[7:4] == 4'h0) ? glyph_mem[ga][4:0]
                                        : rom_row(code, scan_row);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_out   <= 8'h00;
      bus_oe_n  <= 1'b1;
      pixel_row <= 5'h00;
    end else begin
      bus_out   <= bus_out_nxt;
      bus_oe_n  <= bus_oe_n_nxt;
      pixel_row <= pixel_nxt;
    end
  end
endmodule : char_lcd_host_port
`default_nettype wire

// *** tb/char_lcd_host_port_asserts.sv ***
// concurrent checks on the pins of the character display host port
`default_nettype none
module char_lcd_host_port_asserts #(
  parameter int LONG_EXEC_CYCLES = char_lcd_pkg::LONG_EXEC_CYC
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       register_select,
  input wire logic       read_write,
  input wire logic       strobe,
  input wire logic [7:0] bus_in,
  input wire logic [1:0] scan_line,
  input wire logic [4:0] scan_col,
  input wire logic [3:0] scan_row,
  input wire logic [7:0] bus_out,
  input wire logic       bus_oe_n,
  input wire logic       busy_flag,
  input wire logic [4:0] pixel_row
);
  localparam int SHORT = char_lcd_pkg::SHORT_EXEC_CYC;
  localparam int DATA  = char_lcd_pkg::DATA_EXEC_CYC;
  localparam int MAX_BUSY = (LONG_EXEC_CYCLES > DATA) ? LONG_EXEC_CYCLES : DATA;
  logic [15:0] busy_cnt_r, busy_cnt_nxt;
  logic [7:0]  str_hist_r, str_hist_nxt;
  logic [7:0]  rw_hist_r, rw_hist_nxt;
  logic [7:0]  rs_hist_r, rs_hist_nxt;
  // busy length and the last eight pin samples
  always_comb begin
    busy_cnt_nxt = busy_flag ? busy_cnt_r + 16'h0001 : 16'h0000;
    str_hist_nxt = {str_hist_r[6:0], strobe};
    rw_hist_nxt  = {rw_hist_r[6:0], read_write};
    rs_hist_nxt  = {rs_hist_r[6:0], register_select};
  end
  // history starts pessimistic after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_cnt_r <= 16'h0000;
      str_hist_r <= 8'h00;
      rw_hist_r  <= 8'hFF;
      rs_hist_r  <= 8'hFF;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
      str_hist_r <= str_hist_nxt;
      rw_hist_r  <= rw_hist_nxt;
      rs_hist_r  <= rs_hist_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence busy_start;
    $rose(busy_flag);
  endsequence
  sequence busy_end;
    $fell(busy_flag);
  endsequence
  AST_BUSY_HOLD: assert property (busy_start |-> busy_flag [*8])
    else $error("busy flag dropped too soon");
  AST_BUSY_LEN: assert property (busy_end |->
    (busy_cnt_r == LONG_EXEC_CYCLES || busy_cnt_r == SHORT ||
     busy_cnt_r == DATA))
    else $error("busy period has a wrong length");
  AST_BUSY_BOUND: assert property (busy_flag |-> busy_cnt_r < MAX_BUSY)
    else $error("busy period runs too long");
  AST_BUSY_CAUSE: assert property (busy_start |-> (str_hist_r != 8'h00
    && !$past(strobe)))
    else $error("busy raised without a strobe fall");
  AST_OE_CAUSE: assert property (!bus_oe_n |-> (str_hist_r != 8'h00
    && rw_hist_r != 8'h00))
    else $error("bus driven without a read strobe");
  AST_NO_DRIVE_WRITE: assert property ((rw_hist_r == 8'h00
    && !read_write) |-> bus_oe_n)
    else $error("bus driven during a write");
  AST_STATUS_MSB: assert property ((!bus_oe_n && rs_hist_r == 8'h00
    && $stable(busy_flag) && busy_flag == $past(busy_flag, 2))
    |-> bus_out[7] == busy_flag)
    else $error("status top bit differs from busy");
  AST_PIX_COL: assert property ((scan_col > char_lcd_pkg::LAST_COL)
    |=> pixel_row == 5'h00)
    else $error("dots shown beyond column nineteen");
endmodule : char_lcd_host_port_asserts
bind char_lcd_host_port char_lcd_host_port_asserts #(
  .LONG_EXEC_CYCLES(LONG_EXEC_CYCLES)
) u_chk (.mclk(mclk), .rst(rst), .register_select(register_select),
  .read_write(read_write), .strobe(strobe), .bus_in(bus_in),
  .scan_line(scan_line), .scan_col(scan_col), .scan_row(scan_row),
  .bus_out(bus_out), .bus_oe_n(bus_oe_n), .busy_flag(busy_flag),
  .pixel_row(pixel_row));
`default_nettype wire

// *** tb/host_model.sv ***
// behavioural host processor on the display's parallel pins
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe_n,
  output var logic        register_select,
  output var logic        read_write,
  output var logic        strobe,
  output logic      [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  // wire level: device when enabled, else host value or inverted leftover
  assign bus_in = bus_oe_n ? drv : bus_out;
  initial begin
    register_select = 1'b0;
    read_write = 1'b0;
    strobe = 1'b0;
    drv = 8'h00;
  end
  // one strobed transfer, pins held for the whole high phase
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    #5;
    register_select = rs;
    read_write = rw;
    drv = rw ? ~drv : d;
    strobe = 1'b1;
    repeat (8) @(posedge mclk);
    #5;
    q = bus_in;
    strobe = 1'b0;
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : host_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the character display host port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       poll;
    logic       rs;
    logic       rw;
    logic [7:0] d;
    logic       chk;
    logic [7:0] exp;
  } row_s;
  logic       mclk, rst, register_select, read_write, strobe;
  logic       bus_oe_n, busy_flag;
  logic [7:0] bus_in, bus_out, q;
  logic [1:0] scan_line;
  logic [4:0] scan_col, pixel_row;
  logic [3:0] scan_row;
  int         errors = 0;
  int         n_compared = 0;
  // poll, select, read, write byte, compare, expected byte
  row_s rows [39] = '{'{1,0,0,8'h01,0,8'h00}, '{1,0,0,8'h80,0,8'h00},
    '{1,1,0,8'h41,0,8'h00}, '{1,1,0,8'h42,0,8'h00}, '{1,0,1,8'h00,1,8'h02},
    '{1,0,0,8'h80,0,8'h00}, '{1,1,1,8'h00,1,8'h41}, '{1,1,1,8'h00,1,8'h42},
    '{1,0,0,8'h93,0,8'h00}, '{1,1,0,8'h55,0,8'h00}, '{1,0,1,8'h00,1,8'h40},
    '{1,1,0,8'h66,0,8'h00}, '{1,0,0,8'h93,0,8'h00}, '{1,1,1,8'h00,1,8'h55},
    '{1,1,1,8'h00,1,8'h66}, '{1,0,0,8'h40,0,8'h00}, '{1,1,0,8'h1F,0,8'h00},
    '{1,0,1,8'h00,1,8'h01}, '{1,0,0,8'h40,0,8'h00}, '{1,1,1,8'h00,1,8'h1F},
    '{1,0,0,8'h94,0,8'h00}, '{1,1,1,8'h00,1,8'h00}, '{1,0,0,8'hC5,0,8'h00},
    '{1,1,0,8'h00,0,8'h00}, '{1,0,0,8'h80,0,8'h00}, '{0,0,1,8'h00,1,8'h80},
    '{0,1,0,8'h77,0,8'h00}, '{1,0,0,8'h80,0,8'h00}, '{1,1,1,8'h00,1,8'h41},
    '{1,0,0,8'h0C,0,8'h00}, '{1,0,0,8'h04,0,8'h00}, '{1,0,0,8'hC0,0,8'h00},
    '{1,1,0,8'h33,0,8'h00}, '{1,0,1,8'h00,1,8'h13}, '{1,0,0,8'h02,0,8'h00},
    '{1,0,1,8'h00,1,8'h00}, '{1,0,0,8'h06,0,8'h00}, '{1,0,0,8'h49,0,8'h00},
    '{1,1,0,8'h0A,0,8'h00}};
  host_model host (.mclk(mclk), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .bus_in(bus_in));
  char_lcd_host_port #(.LONG_EXEC_CYCLES(100)) uut (.mclk(mclk), .rst(rst),
    .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .bus_in(bus_in), .scan_line(scan_line),
    .scan_col(scan_col), .scan_row(scan_row), .bus_out(bus_out),
    .bus_oe_n(bus_oe_n), .busy_flag(busy_flag), .pixel_row(pixel_row));
  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // status polling until the busy bit reads zero
  task automatic wait_ready;
    logic [7:0] s;
    for (int n = 0; n < 200; n++) begin
      host.xfer(1'b0, 1'b1, 8'h00, s);
      if (s[7] === 1'b0) return;
    end
    errors++;
    $display("mismatch t=%0t got %h exp %h", $time, s, 8'h00);
  endtask : wait_ready
  // one scan lookup, answer one cycle later
  task automatic pix(input logic [1:0] l, input logic [4:0] c,
                     input logic [3:0] r, input logic [7:0] exp);
    @(posedge mclk);
    #5;
    scan_line = l;
    scan_col = c;
    scan_row = r;
    repeat (2) @(posedge mclk);
    #5;
    chk(8'(pixel_row), exp);
  endtask : pix
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // watchdog far beyond the expected run
  initial begin
    repeat (80000) @(posedge mclk);
    errors++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    scan_line = 2'h0;
    scan_col = 5'h00;
    scan_row = 4'h0;
    repeat (8) @(posedge mclk);
    #5;
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].poll) wait_ready();
      host.xfer(rows[i].rs, rows[i].rw, rows[i].d, q);
      if (rows[i].chk) chk(q, rows[i].exp);
    end
    $display("transfer table done");
    wait_ready();
    pix(2'h1, 5'h05, 4'h0, 8'h1F);
    pix(2'h1, 5'h05, 4'h8, 8'h00);
    pix(2'h0, 5'h14, 4'h0, 8'h00);
    pix(2'h0, 5'h00, 4'h2, 8'h05);
    pix(2'h1, 5'h05, 4'h9, 8'h00);
    // tall font: ten rows, glyph ram slot addressed by code bits 2:1
    host.xfer(1'b0, 1'b0, 8'h24, q);
    wait_ready();
    pix(2'h1, 5'h05, 4'h9, 8'h0A);
    pix(2'h1, 5'h05, 4'hA, 8'h00);
    $display("scan lookups done");
    wait_ready();
    host.xfer(1'b0, 1'b0, 8'h01, q);
    @(posedge mclk);
    #5;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    #5;
    chk({6'h00, bus_oe_n, busy_flag}, 8'h02);
    chk(bus_out, 8'h00);
    chk(8'(pixel_row), 8'h00);
    rst = 1'b0;
    host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h00);
    $display("second reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
